// *** hdl/udr_source_select.sv ***
/*
 * Dual-role USB configuration and status-source selection bank.
 * Holds the system configuration, control/status and auxiliary
 * status registers behind an AHB-Lite slave with one wait state.
 * Assumes all inputs are synchronous to hclk, hsel is decoded
 * upstream, and the pin-mux and chip configuration inputs are stable.
 */
// How it works
// - Status source 0: transceiver status bits are plain software read/write bits.
// - Status source 1: ID, VBUS valid and both session-end bits read as zero.
// - Status source 1: B-valid follows VBUS pin if muxed; device VBUS equals B-valid.
// - Status source 1: software writes to the five status bits are dropped.
// - Pin-mux source picks local register fields at 0, chip module at 1.
// - Effective host enable 0 stops host clock and holds host in reset.
// - Host clock runs only with 48 MHz clock active and reset released.
// - Local host enable resets to one on soft and hardware reset.
// - Reading host enable returns the effective value from either source.
// - Pin-mux source 1: writes to local mux, speed, attach, enable ignored.
// - Link speed bit: 0 low speed, 1 full speed; resets to zero.
// - Link attach bit: 0 detached, 1 attached; resets to zero.
// - Six-bit mux mode in low bits selects pin mux; resets to zero.
`timescale 1ns/100ps

module udr_source_select (
  input  wire logic                   hclk,
  input  wire logic                   hresetn,
  input  wire logic                   clk_en,
  input  wire logic                   soft_reset,
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  output logic                        hreadyout,
  output logic                        hresp,
  output logic [31:0]                 hrdata,
  input  wire logic                   vbus_sense_pin,
  input  wire logic                   vbus_pin_muxed,
  input  udr_pkg::udr_link_cfg_s      chip_module_config,
  input  wire logic                   usb_clk48_active,
  input  wire logic                   periph_reset,
  output udr_pkg::udr_xcvr_stat_s     xcvr_status,
  output logic                        device_vbus,
  output udr_pkg::udr_link_cfg_s      link_cfg,
  output logic                        host_clk_enable,
  output logic                        host_reset_hold
);

  // ----------------------------------------------------------------
  // Address decode helper
  // ----------------------------------------------------------------

  // True when a captured offset selects the given register.
  function automatic logic hit(input logic [udr_pkg::OFS_W-1:0] ofs,
                               input logic [udr_pkg::OFS_W-1:0] reg_ofs);
    hit = (ofs == reg_ofs);
  endfunction

  // True for a full-word write, in its wait cycle, to the given register.
  // Writing in the wait cycle lets the register settle before the master
  // sees hready again, so a read right behind it returns the new value.
  function automatic logic wr_hit(input logic                      valid,
                                  input logic                      write,
                                  input logic                      waiting,
                                  input logic [udr_pkg::OFS_W-1:0] ofs,
                                  input logic [udr_pkg::OFS_W-1:0] reg_ofs);
    wr_hit = valid & write & waiting & hit(ofs, reg_ofs);
  endfunction

  // ----------------------------------------------------------------
  // Storage and bus pipeline
  // ----------------------------------------------------------------
  logic                          stat_src_reg;
  logic                          pmux_src_reg;
  udr_pkg::udr_link_cfg_s        local_cfg_reg;
  udr_pkg::udr_xcvr_stat_s       sw_stat_reg;
  logic                          dp_valid_reg;
  logic                          dp_write_reg;
  logic [udr_pkg::OFS_W-1:0]     dp_ofs_reg;
  logic                          hreadyout_reg;
  logic [31:0]                   hrdata_reg;
  udr_pkg::udr_xcvr_stat_s       stat_out_reg;
  logic                          dev_vbus_reg;
  udr_pkg::udr_link_cfg_s        cfg_out_reg;
  logic                          host_clk_reg;
  logic                          host_rst_reg;

  udr_pkg::udr_link_cfg_s        eff_cfg;
  udr_pkg::udr_xcvr_stat_s       eff_stat;
  logic                          take;
  logic                          wr_cfg;
  logic                          wr_ctrl;
  logic                          wr_aux;
  logic                          stat_wr_ok;
  logic [31:0]                   rd_next;

  // ----------------------------------------------------------------
  // Source selection
  // ----------------------------------------------------------------

  // Effective link configuration, chosen by the pin-mux source bit.
  assign eff_cfg = pmux_src_reg ? chip_module_config : local_cfg_reg;

  // Effective transceiver status. In forced mode the stored software
  // values are kept but hidden, so switching back restores them.
  always_comb begin
    eff_stat = sw_stat_reg;
    if (stat_src_reg) begin
      eff_stat.id_pin_state    = 1'b0;
      eff_stat.a_vbus_valid    = 1'b0;
      eff_stat.b_session_end   = 1'b0;
      eff_stat.a_session_end   = 1'b0;
      eff_stat.b_session_valid = vbus_pin_muxed & vbus_sense_pin;
    end
  end

  // ----------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------

  // Address phase is taken only while the bus is ready.
  // The clock enable gates the capture flops, so it is not repeated here.
  assign take = hsel & htrans[1] & hready;

  // Write strobes in the wait cycle of the data phase, full words only.
  assign wr_cfg  = wr_hit(dp_valid_reg, dp_write_reg, ~hreadyout_reg, dp_ofs_reg, udr_pkg::OFS_SYS_CONFIG);
  assign wr_ctrl = wr_hit(dp_valid_reg, dp_write_reg, ~hreadyout_reg, dp_ofs_reg, udr_pkg::OFS_CTRL_STAT);
  assign wr_aux  = wr_hit(dp_valid_reg, dp_write_reg, ~hreadyout_reg, dp_ofs_reg, udr_pkg::OFS_AUX_STAT);
  assign stat_wr_ok = ~stat_src_reg;

  // Capture of the address phase; one wait state lets hrdata be a flop.
  // A write narrower than a word is dropped here, so it never lands.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_valid_reg  <= 1'b0;
      dp_write_reg  <= 1'b0;
      dp_ofs_reg    <= 12'h000;
      hreadyout_reg <= 1'b1;
    end else if (clk_en) begin
      if (take) begin
        dp_valid_reg  <= (hsize == udr_pkg::HSIZE_WORD) | ~hwrite;
        dp_write_reg  <= hwrite;
        dp_ofs_reg    <= haddr[udr_pkg::OFS_W-1:0];
        hreadyout_reg <= 1'b0;
      end else if (!hreadyout_reg) begin
        dp_valid_reg  <= 1'b0;
        hreadyout_reg <= 1'b1;
      end
    end
  end

  // Read mux; reserved and unmapped locations read as zero.
  // Link fields read back the stored local values; host enable reads the one in force.
  always_comb begin
    rd_next = 32'h0000_0000;
    if (hit(dp_ofs_reg, udr_pkg::OFS_SYS_CONFIG)) begin
      rd_next[udr_pkg::STAT_SRC_BIT] = stat_src_reg;
      rd_next[udr_pkg::PMUX_SRC_BIT] = pmux_src_reg;
      rd_next[udr_pkg::HOST_EN_BIT]  = eff_cfg.host_controller_enable;
      rd_next[udr_pkg::SPEED_BIT]    = local_cfg_reg.link_model_speed;
      rd_next[udr_pkg::ATTACH_BIT]   = local_cfg_reg.link_model_attach;
      rd_next[udr_pkg::MODE_LSB +: udr_pkg::MODE_W] = local_cfg_reg.usb_pin_mux_select;
    end else if (hit(dp_ofs_reg, udr_pkg::OFS_CTRL_STAT)) begin
      rd_next[udr_pkg::A_SVLD_BIT] = eff_stat.a_session_valid;
      rd_next[udr_pkg::B_SEND_BIT] = eff_stat.b_session_end;
      rd_next[udr_pkg::B_SVLD_BIT] = eff_stat.b_session_valid;
      rd_next[udr_pkg::A_VVLD_BIT] = eff_stat.a_vbus_valid;
      rd_next[udr_pkg::ID_BIT]     = eff_stat.id_pin_state;
    end else if (hit(dp_ofs_reg, udr_pkg::OFS_AUX_STAT)) begin
      rd_next[udr_pkg::A_SEND_BIT] = eff_stat.a_session_end;
    end
  end

  // Read data is registered at the end of the wait cycle.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_reg <= 32'h0000_0000;
    end else if (clk_en) begin
      if (dp_valid_reg && !dp_write_reg && !hreadyout_reg) begin
        hrdata_reg <= rd_next;
      end
    end
  end

  // ----------------------------------------------------------------
  // System configuration register
  // ----------------------------------------------------------------

  // Source selectors are always writable; local link fields only while
  // locally sourced, so a chip-module session cannot disturb them.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stat_src_reg <= udr_pkg::RST_STAT_SRC;
      pmux_src_reg <= udr_pkg::RST_PMUX_SRC;
      local_cfg_reg.host_controller_enable <= udr_pkg::RST_HOST_EN;
      local_cfg_reg.link_model_speed       <= udr_pkg::RST_SPEED;
      local_cfg_reg.link_model_attach      <= udr_pkg::RST_ATTACH;
      local_cfg_reg.usb_pin_mux_select     <= udr_pkg::RST_MODE;
    end else if (clk_en) begin
      if (soft_reset) begin
        stat_src_reg <= udr_pkg::RST_STAT_SRC;
        pmux_src_reg <= udr_pkg::RST_PMUX_SRC;
        local_cfg_reg.host_controller_enable <= udr_pkg::RST_HOST_EN;
        local_cfg_reg.link_model_speed       <= udr_pkg::RST_SPEED;
        local_cfg_reg.link_model_attach      <= udr_pkg::RST_ATTACH;
        local_cfg_reg.usb_pin_mux_select     <= udr_pkg::RST_MODE;
      end else if (wr_cfg) begin
        stat_src_reg <= hwdata[udr_pkg::STAT_SRC_BIT];
        pmux_src_reg <= hwdata[udr_pkg::PMUX_SRC_BIT];
        if (!pmux_src_reg) begin
          local_cfg_reg.host_controller_enable <= hwdata[udr_pkg::HOST_EN_BIT];
          local_cfg_reg.link_model_speed       <= hwdata[udr_pkg::SPEED_BIT];
          local_cfg_reg.link_model_attach      <= hwdata[udr_pkg::ATTACH_BIT];
          local_cfg_reg.usb_pin_mux_select     <= hwdata[udr_pkg::MODE_LSB +: udr_pkg::MODE_W];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Transceiver status registers
  // ----------------------------------------------------------------

  // A-session valid is outside the forced set and stays writable.
  // A-session end sits alone in the auxiliary register at its own offset.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sw_stat_reg <= '{default: udr_pkg::RST_STATUS};
    end else if (clk_en) begin
      if (soft_reset) begin
        sw_stat_reg <= '{default: udr_pkg::RST_STATUS};
      end else begin
        if (wr_ctrl) begin
          sw_stat_reg.a_session_valid <= hwdata[udr_pkg::A_SVLD_BIT];
        end
        if (wr_ctrl && stat_wr_ok) begin
          sw_stat_reg.b_session_end   <= hwdata[udr_pkg::B_SEND_BIT];
          sw_stat_reg.b_session_valid <= hwdata[udr_pkg::B_SVLD_BIT];
          sw_stat_reg.a_vbus_valid    <= hwdata[udr_pkg::A_VVLD_BIT];
          sw_stat_reg.id_pin_state    <= hwdata[udr_pkg::ID_BIT];
        end
        if (wr_aux && stat_wr_ok) begin
          sw_stat_reg.a_session_end <= hwdata[udr_pkg::A_SEND_BIT];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs to the USB controllers and clock control
  // ----------------------------------------------------------------

  // Status outputs lag the effective status by one cycle.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stat_out_reg <= '{default: udr_pkg::RST_STATUS};
      dev_vbus_reg <= 1'b0;
    end else if (clk_en) begin
      stat_out_reg <= eff_stat;
      dev_vbus_reg <= eff_stat.b_session_valid;
    end
  end

  // Link configuration for the pin mux and the transceiverless link model.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_out_reg <= '0;
    end else if (clk_en) begin
      cfg_out_reg <= eff_cfg;
    end
  end

  // Host clock gate and reset hold. The gate is off during reset so the
  // host never sees a partial clock pulse. The hold follows the enable
  // alone: losing the 48 MHz clock stops the host but does not reset it.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      host_clk_reg <= 1'b0;
      host_rst_reg <= 1'b1;
    end else if (clk_en) begin
      host_clk_reg <= eff_cfg.host_controller_enable & usb_clk48_active & ~periph_reset;
      host_rst_reg <= ~eff_cfg.host_controller_enable;
    end
  end

  assign hreadyout       = hreadyout_reg;
  assign hresp           = udr_pkg::HRESP_OKAY;
  assign hrdata          = hrdata_reg;
  assign xcvr_status     = stat_out_reg;
  assign device_vbus     = dev_vbus_reg;
  assign link_cfg        = cfg_out_reg;
  assign host_clk_enable = host_clk_reg;
  assign host_reset_hold = host_rst_reg;

endmodule

// *** hdl/udr_pkg.sv ***
/*
 * Package for the dual-role USB source-select register bank.
 * Holds register offsets, field positions, reset values and the
 * structs that carry the status and link configuration groups.
 * Assumes a 32-bit AHB-Lite bus with word-aligned registers.
 */
package udr_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses within the block)
  // ----------------------------------------------------------------
  localparam int          OFS_W          = 12;
  localparam logic [11:0] OFS_SYS_CONFIG = 12'h000;
  localparam logic [11:0] OFS_CTRL_STAT  = 12'h004;
  localparam logic [11:0] OFS_AUX_STAT   = 12'h008;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int STAT_SRC_BIT = 10;
  localparam int PMUX_SRC_BIT = 9;
  localparam int HOST_EN_BIT  = 8;
  localparam int SPEED_BIT    = 7;
  localparam int ATTACH_BIT   = 6;
  localparam int MODE_LSB     = 0;
  localparam int MODE_W       = 6;
  localparam int A_SVLD_BIT   = 20;
  localparam int B_SEND_BIT   = 19;
  localparam int B_SVLD_BIT   = 18;
  localparam int A_VVLD_BIT   = 17;
  localparam int ID_BIT       = 16;
  localparam int A_SEND_BIT   = 0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic             RST_STAT_SRC = 1'b0;
  localparam logic             RST_PMUX_SRC = 1'b0;
  localparam logic             RST_HOST_EN  = 1'b1;
  localparam logic             RST_SPEED    = 1'b0;
  localparam logic             RST_ATTACH   = 1'b0;
  localparam logic [MODE_W-1:0] RST_MODE    = 6'h00;
  localparam logic             RST_STATUS   = 1'b0;

  // ----------------------------------------------------------------
  // Bus encodings
  // ----------------------------------------------------------------
  localparam logic [2:0] HSIZE_WORD = 3'b010;
  localparam logic       HRESP_OKAY = 1'b0;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [MODE_W-1:0] usb_pin_mux_select;
    logic              link_model_speed;
    logic              link_model_attach;
    logic              host_controller_enable;
  } udr_link_cfg_s;

  typedef struct packed {
    logic id_pin_state;
    logic a_vbus_valid;
    logic a_session_valid;
    logic a_session_end;
    logic b_session_end;
    logic b_session_valid;
  } udr_xcvr_stat_s;

endpackage

// *** verif/udr_source_select_asserts.sv ***
/* Checker for the dual-role USB source-select bank: transfer timing, forced
   status, host clock gating and pin-mux source. Assumes word transfers only. */
`timescale 1ns/100ps
module udr_source_select_asserts (
  input wire logic               hclk,
  input wire logic               hresetn,
  input wire logic               clk_en,
  input wire logic               soft_reset,
  input wire logic               hsel,
  input wire logic [31:0]        haddr,
  input wire logic [1:0]         htrans,
  input wire logic               hwrite,
  input wire logic [31:0]        hwdata,
  input wire logic               hready,
  input wire logic               hreadyout,
  input wire logic               vbus_sense_pin,
  input wire logic               vbus_pin_muxed,
  input udr_pkg::udr_link_cfg_s  chip_module_config,
  input wire logic               usb_clk48_active,
  input wire logic               periph_reset,
  input udr_pkg::udr_xcvr_stat_s xcvr_status,
  input wire logic               device_vbus,
  input udr_pkg::udr_link_cfg_s  link_cfg,
  input wire logic               host_clk_enable,
  input wire logic               host_reset_hold
);
  logic take;
  logic wr_sys_q;
  logic stat_src_q;
  logic pmux_src_q;
  assign take = clk_en && hsel && htrans[1] && hready;
  // Shadow of both selectors, since the checker cannot see the register bank.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_sys_q   <= 1'b0;
      stat_src_q <= 1'b0;
      pmux_src_q <= 1'b0;
    end else if (clk_en) begin
      wr_sys_q <= take && hwrite && haddr[11:0] == udr_pkg::OFS_SYS_CONFIG;
      if (soft_reset) begin
        stat_src_q <= 1'b0;
        pmux_src_q <= 1'b0;
      end else if (wr_sys_q) begin
        stat_src_q <= hwdata[udr_pkg::STAT_SRC_BIT];
        pmux_src_q <= hwdata[udr_pkg::PMUX_SRC_BIT];
      end
    end
  end
  // One domain, so clock and reset are given once for every property.
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_wait_low; take |=> !hreadyout; endproperty
  a_wait_low: assert property (p_wait_low) else $error("transfer taken without its wait state");
  property p_wait_end; !hreadyout && clk_en |=> hreadyout; endproperty
  a_wait_end: assert property (p_wait_end) else $error("wait state lasted more than one cycle");
  property p_forced_zero; $past(stat_src_q) && $past(clk_en) |-> !xcvr_status.id_pin_state &&
    !xcvr_status.a_vbus_valid && !xcvr_status.b_session_end && !xcvr_status.a_session_end; endproperty
  a_forced_zero: assert property (p_forced_zero) else $error("forced status bit not zero");
  property p_forced_bvld; $past(stat_src_q) && $past(clk_en) |->
    xcvr_status.b_session_valid == $past(vbus_pin_muxed && vbus_sense_pin); endproperty
  a_forced_bvld: assert property (p_forced_bvld) else $error("session valid not following pin");
  property p_vbus_tie; device_vbus == xcvr_status.b_session_valid; endproperty
  a_vbus_tie: assert property (p_vbus_tie) else $error("device vbus differs from session valid");
  property p_pmux_chip; $past(pmux_src_q) && $past(clk_en) |-> link_cfg == $past(chip_module_config); endproperty
  a_pmux_chip: assert property (p_pmux_chip) else $error("link config not from chip module");
  property p_reset_hold; host_reset_hold == !link_cfg.host_controller_enable; endproperty
  a_reset_hold: assert property (p_reset_hold) else $error("host reset hold wrong for enable");
  property p_host_clk; $past(clk_en) |-> host_clk_enable ==
    (link_cfg.host_controller_enable && $past(usb_clk48_active) && !$past(periph_reset)); endproperty
  a_host_clk: assert property (p_host_clk) else $error("host clock enable wrong");
  property p_soft_host; soft_reset && clk_en ##1 clk_en |=> link_cfg.host_controller_enable; endproperty
  a_soft_host: assert property (p_soft_host) else $error("host enable not set by soft reset");
  c_forced: cover property (stat_src_q && device_vbus);
  c_chip: cover property (pmux_src_q && link_cfg.host_controller_enable);
  c_soft: cover property (soft_reset && clk_en);
endmodule
bind udr_source_select udr_source_select_asserts udr_source_select_asserts_i (
  .hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .soft_reset(soft_reset), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .vbus_sense_pin(vbus_sense_pin), .vbus_pin_muxed(vbus_pin_muxed),
  .chip_module_config(chip_module_config), .usb_clk48_active(usb_clk48_active),
  .periph_reset(periph_reset), .xcvr_status(xcvr_status), .device_vbus(device_vbus),
  .link_cfg(link_cfg), .host_clk_enable(host_clk_enable), .host_reset_hold(host_reset_hold));

// *** verif/test_udr_source_select.sv ***
/* Self-checking bench for the dual-role USB source-select bank.
   Acts as the single AHB-Lite master and drives every other input itself. */
`timescale 1ns/100ps
`define CHK(got, exp) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) begin \
      n_fail++; \
      $display("unexpected at %0t: got %h expected %h", $time, got, exp); \
    end \
  end
module test_udr_source_select;
  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic [8:0]  link;
    logic [5:0]  xcvr;
  } udr_row_s;
  logic                    hclk, hresetn, clk_en, soft_reset, hsel, hwrite, hreadyout, hresp, device_vbus;
  logic                    vbus_sense_pin, vbus_pin_muxed, usb_clk48_active, periph_reset;
  logic                    host_clk_enable, host_reset_hold;
  logic [31:0]             haddr, hwdata, hrdata, rdq;
  logic [1:0]              htrans;
  logic [2:0]              hsize;
  udr_pkg::udr_link_cfg_s  chip_module_config, link_cfg;
  udr_pkg::udr_xcvr_stat_s xcvr_status;
  int                      n_fail, total_checks, cycles;
  // Local-source rows: write, read back, then the outputs the write should give.
  // Attach is only set with the host enabled, and no row models a resistive ID.
  udr_row_s rows [7] = '{
    '{12'h000, 32'h000001c5, 32'h000001c5, 9'h02f, 6'h00},
    '{12'h000, 32'hfffff83f, 32'h0000003f, 9'h1f8, 6'h00},
    '{12'h004, 32'hffffffff, 32'h001f0000, 9'h1f8, 6'h3b},
    '{12'h008, 32'hffffffff, 32'h00000001, 9'h1f8, 6'h3f},
    '{12'h00c, 32'hffffffff, 32'h00000000, 9'h1f8, 6'h3f},
    '{12'h004, 32'h00050000, 32'h00050000, 9'h1f8, 6'h25},
    '{12'h000, 32'h00000180, 32'h00000180, 9'h005, 6'h25}};
  udr_source_select udr_source_select_i (
    .hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .soft_reset(soft_reset), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .vbus_sense_pin(vbus_sense_pin), .vbus_pin_muxed(vbus_pin_muxed),
    .chip_module_config(chip_module_config), .usb_clk48_active(usb_clk48_active),
    .periph_reset(periph_reset), .xcvr_status(xcvr_status), .device_vbus(device_vbus),
    .link_cfg(link_cfg), .host_clk_enable(host_clk_enable), .host_reset_hold(host_reset_hold));
  // Free-running clock at 100 MHz.
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  // Cuts a hang short; the whole run needs well under a thousand cycles.
  always @(posedge hclk) begin
    cycles++;
    if (cycles > 3000) begin
      n_fail++;
      results();
    end
  end
  task automatic results;
    if (n_fail == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // One word transfer; entered just after a rising edge, holds each phase until hready.
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr  <= {20'h00000, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rdq = hrdata;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h00000000);
    `CHK(rdq, e)
    `CHK(hresp, udr_pkg::HRESP_OKAY)
  endtask
  // Outputs lag their source by one registered cycle.
  task automatic settle;
    repeat (2) @(posedge hclk);
  endtask
  // Main sequence: reset values, table rows, forced status, chip source, clock enable and both resets.
  initial begin
    {hresetn, soft_reset, hsel, hwrite, vbus_sense_pin, vbus_pin_muxed, periph_reset} = 7'h00;
    {haddr, hwdata, htrans} = 66'h0;
    hsize = udr_pkg::HSIZE_WORD;
    clk_en = 1'b1;
    usb_clk48_active = 1'b1;
    chip_module_config = 9'h000;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rd(12'h000, 32'h00000100);
    `CHK(link_cfg, 9'h001)
    `CHK(host_reset_hold, 1'b0)
    foreach (rows[i]) begin
      bus(1'b1, rows[i].addr, rows[i].wdata);
      rd(rows[i].addr, rows[i].rdata);
      `CHK(link_cfg, rows[i].link)
      `CHK(xcvr_status, rows[i].xcvr)
      `CHK(host_reset_hold, ~rows[i].link[0])
      `CHK(host_clk_enable, rows[i].link[0])
    end
    bus(1'b1, 12'h000, 32'h00000500);
    for (int i = 0; i < 4; i++) begin
      vbus_pin_muxed <= i[1];
      vbus_sense_pin <= i[0];
      settle();
      `CHK(xcvr_status, 6'(i == 3))
      `CHK(device_vbus, i == 3)
    end
    bus(1'b1, 12'h004, 32'hffffffff);
    bus(1'b1, 12'h008, 32'h00000000);
    rd(12'h004, 32'h00140000);
    bus(1'b1, 12'h000, 32'h00000100);
    rd(12'h004, 32'h00150000);
    rd(12'h008, 32'h00000001);
    chip_module_config <= 9'h154;
    bus(1'b1, 12'h000, 32'h00000200);
    settle();
    `CHK(link_cfg, 9'h154)
    `CHK(host_reset_hold, 1'b1)
    rd(12'h000, 32'h00000200);
    bus(1'b1, 12'h000, 32'h000003ff);
    chip_module_config <= 9'h155;
    settle();
    rd(12'h000, 32'h00000300);
    `CHK(host_clk_enable, 1'b1)
    periph_reset <= 1'b1;
    settle();
    `CHK(host_clk_enable, 1'b0)
    periph_reset <= 1'b0;
    usb_clk48_active <= 1'b0;
    settle();
    `CHK(host_clk_enable, 1'b0)
    // With the clock enable low the gate must not follow the returning clock.
    clk_en <= 1'b0;
    usb_clk48_active <= 1'b1;
    settle();
    `CHK(host_clk_enable, 1'b0)
    clk_en <= 1'b1;
    settle();
    `CHK(host_clk_enable, 1'b1)
    bus(1'b1, 12'h000, 32'h00000000);
    settle();
    `CHK(link_cfg, 9'h000)
    soft_reset <= 1'b1;
    @(posedge hclk);
    soft_reset <= 1'b0;
    settle();
    `CHK(link_cfg, 9'h001)
    rd(12'h000, 32'h00000100);
    rd(12'h004, 32'h00000000);
    // Hardware reset in mid-run after the link model and forced status are set.
    bus(1'b1, 12'h000, 32'h000005c0);
    settle();
    `CHK(link_cfg, 9'h007)
    `CHK(xcvr_status, 6'h01)
    hresetn <= 1'b0;
    settle();
    `CHK(link_cfg, 9'h000)
    `CHK(host_reset_hold, 1'b1)
    hresetn <= 1'b1;
    rd(12'h000, 32'h00000100);
    `CHK(link_cfg, 9'h001)
    `CHK(xcvr_status, 6'h00)
    results();
  end
endmodule
